// ===== iowd_pkg.sv
// How it works
// - Enabled watchdog counts down; restart reloads interval.
// - Reaching zero asserts system reset output.
// - Port read restarts the counter.
// - Port write loads the control register.
// - Bits 2..0 pick one of eight intervals.
// - Reset clears control register to zero.
// - New settings take effect after the write.
package iowd_pkg;
  // ----------------------------------------
  // Port map
  // ----------------------------------------
  localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'hF2;
  localparam logic [7:0] WATCHDOG_CONTROL_RESET = 8'h00;
  localparam int WATCHDOG_ENABLE_BIT = 3;
  localparam int INTERVAL_LSB = 0;
  localparam int INTERVAL_W = 3;
  localparam int INTERVAL_MAX_SECS = 128;
  localparam int INTERVAL_MIN_SECS = 1;
  localparam logic [7:0] RDATA_IDLE = 8'h00;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 40000000;
  localparam int TICK_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_S;
  localparam int SECONDS_W = 8;
  localparam int RESET_PULSE_CYCLES = 16;
  localparam int EXPIRE_SECS = 1;
  localparam int PULSE_LAST = 1;
endpackage

// ===== iowd_tick.sv
`timescale 1ns/1ps
module iowd_tick #(
  parameter int CYCLES = iowd_pkg::TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic restart,
  output logic tick
);
  localparam int CW = $clog2(CYCLES);
  logic [CW-1:0] count_reg;

  if (CYCLES < 2) begin : g_bad_cycles
    $error("iowd_tick needs at least two cycles per tick");
  end

  // A restart also realigns the prescaler so every interval begun by a restart is at least its nominal length.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= '0;
      tick <= 1'b0;
    end else if (restart || count_reg == CW'(CYCLES - 1)) begin
      count_reg <= '0;
      tick <= !restart;
    end else begin
      count_reg <= count_reg + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule

// ===== iowd_top.sv
`timescale 1ns/1ps
module iowd_top #(
  parameter int TICK_CYCLES = iowd_pkg::TICK_CYCLES,
  parameter int RESET_PULSE_CYCLES = iowd_pkg::RESET_PULSE_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic sys_reset,
  output logic [7:0] watchdog_control_out
);
  // ----------------------------------------
  // Types and sizes
  // ----------------------------------------
  typedef enum logic [1:0] {IOWD_IDLE, IOWD_COUNT, IOWD_FIRE} iowd_state_e;

  localparam int PW = $clog2(RESET_PULSE_CYCLES + 1);
  localparam int SW = iowd_pkg::SECONDS_W;
  localparam int IW = iowd_pkg::INTERVAL_W;
  localparam int CODES = 1 << IW;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // The pulse and seconds counters are sized from these values, so values they cannot hold are refused here.
  if (RESET_PULSE_CYCLES < 1) begin : g_bad_pulse
    $error("iowd_top needs a reset pulse of at least one cycle");
  end
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("iowd_top needs at least two clock cycles per second tick");
  end
  if (iowd_pkg::INTERVAL_MAX_SECS >= (1 << SW)) begin : g_bad_seconds
    $error("iowd_top seconds counter is too narrow for the longest interval");
  end
  if (iowd_pkg::WATCHDOG_ENABLE_BIT >= $bits(io_wdata) || iowd_pkg::INTERVAL_LSB + IW > $bits(io_wdata)) begin : g_bad_fields
    $error("iowd_top control fields do not fit the control byte");
  end

  // ----------------------------------------
  // Internal signals
  // ----------------------------------------
  logic [7:0] watchdog_control_reg;
  logic [SW-1:0] seconds_reg;
  logic [SW-1:0] interval_secs;
  logic [PW-1:0] pulse_reg;
  iowd_state_e state_reg;
  logic hit;
  logic read_hit;
  logic write_hit;
  logic restart;
  logic tick;
  logic expire;
  logic pulse_last;
  logic watchdog_enable_bit;
  logic [IW-1:0] interval_select_field;
  wire [SW-1:0] interval_table [CODES];

  // ----------------------------------------
  // Port decode
  // ----------------------------------------
  assign hit = io_addr == iowd_pkg::WATCHDOG_CONTROL_ADDR;
  assign read_hit = hit && io_rd;
  assign write_hit = hit && io_wr;
  // A write restarts the count as well, so a changed interval never inherits a partly used one.
  assign restart = read_hit || write_hit;
  assign watchdog_enable_bit = watchdog_control_reg[iowd_pkg::WATCHDOG_ENABLE_BIT];
  assign interval_select_field = watchdog_control_reg[iowd_pkg::INTERVAL_LSB +: IW];

  // ----------------------------------------
  // Interval decode
  // ----------------------------------------
  // Codes 2 to 7 each double the one below; code zero is the longest interval, not the shortest.
  for (genvar code = 0; code < CODES; code++) begin : g_interval
    if (code == 0) begin : g_longest
      assign interval_table[code] = SW'(iowd_pkg::INTERVAL_MAX_SECS);
    end else begin : g_doubling
      assign interval_table[code] = SW'(iowd_pkg::INTERVAL_MIN_SECS << (code - 1));
    end
  end

  assign interval_secs = interval_table[interval_select_field];

  // ----------------------------------------
  // Second tick
  // ----------------------------------------
  // The prescaler restarts on every access to the watchdog port, so an interval begun by an access is never cut short by a partly elapsed second.
  iowd_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .mclk(mclk),
    .rstn(rstn),
    .restart(restart),
    .tick(tick)
  );

  // ----------------------------------------
  // Countdown status
  // ----------------------------------------
  // Expiry needs the tick that empties the last second with no read or write of the watchdog port in the same cycle.
  assign expire = state_reg == IOWD_COUNT && watchdog_enable_bit && !restart && tick &&
    seconds_reg == SW'(iowd_pkg::EXPIRE_SECS);
  assign pulse_last = pulse_reg == PW'(iowd_pkg::PULSE_LAST);

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      watchdog_control_reg <= iowd_pkg::WATCHDOG_CONTROL_RESET;
    end else if (write_hit) begin
      watchdog_control_reg <= io_wdata;
    end
  end

  // The host sees the control byte only on a read of the port; other addresses return the idle value.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      io_rdata <= iowd_pkg::RDATA_IDLE;
    end else if (read_hit) begin
      io_rdata <= watchdog_control_reg;
    end else begin
      io_rdata <= iowd_pkg::RDATA_IDLE;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      watchdog_control_out <= iowd_pkg::WATCHDOG_CONTROL_RESET;
    end else begin
      watchdog_control_out <= watchdog_control_reg;
    end
  end

  // ----------------------------------------
  // Countdown state
  // ----------------------------------------
  // A write while counting always passes through idle, so the next count starts from the newly written interval.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= IOWD_IDLE;
    end else begin
      case (state_reg)
        IOWD_IDLE: begin
          if (watchdog_enable_bit) begin
            state_reg <= IOWD_COUNT;
          end
        end
        IOWD_COUNT: begin
          if (!watchdog_enable_bit || write_hit) begin
            state_reg <= IOWD_IDLE;
          end else if (expire) begin
            state_reg <= IOWD_FIRE;
          end
        end
        IOWD_FIRE: begin
          if (pulse_last) begin
            state_reg <= IOWD_IDLE;
          end
        end
        default: begin
          state_reg <= IOWD_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Seconds counter
  // ----------------------------------------
  // A read while counting reloads the interval, and the prescaler restarts in the same cycle.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      seconds_reg <= '0;
    end else begin
      case (state_reg)
        IOWD_IDLE: begin
          seconds_reg <= interval_secs;
        end
        IOWD_COUNT: begin
          if (restart) begin
            seconds_reg <= interval_secs;
          end else if (expire) begin
            seconds_reg <= '0;
          end else if (tick) begin
            seconds_reg <= seconds_reg - 1'b1;
          end
        end
        default: begin
          seconds_reg <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Reset pulse
  // ----------------------------------------
  // The pulse length is fixed by a parameter; the host cannot shorten it by touching the port.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pulse_reg <= '0;
    end else if (expire) begin
      pulse_reg <= PW'(RESET_PULSE_CYCLES);
    end else if (state_reg == IOWD_FIRE) begin
      pulse_reg <= pulse_reg - 1'b1;
    end
  end

  // ----------------------------------------
  // System reset output
  // ----------------------------------------
  // The output is low in every state but fire, so a disable during the pulse still lets it finish.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sys_reset <= 1'b0;
    end else if (expire) begin
      sys_reset <= 1'b1;
    end else if (state_reg != IOWD_FIRE || pulse_last) begin
      sys_reset <= 1'b0;
    end
  end
endmodule

// ===== iowd_chk.sv
`timescale 1ns/1ps
module iowd_chk #(parameter int TICK_CYCLES = 10, parameter int RESET_PULSE_CYCLES = 4) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic sys_reset,
  input wire logic [7:0] watchdog_control_out
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  logic wh, rh, armed;
  int cnt, lim, hi;
  assign wh = io_wr && io_addr == 8'hF2;
  assign rh = io_rd && io_addr == 8'hF2;
  assign lim = TICK_CYCLES << (watchdog_control_out[2:0] == 3'h0 ? 7 : watchdog_control_out[2:0] - 1);
  // Only the first timeout after a host access is timed; later ones restart from the pulse.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      hi <= 0;
      armed <= 1'b0;
    end else begin
      cnt <= (wh || rh) ? 0 : cnt + 1;
      hi <= sys_reset ? hi + 1 : 0;
      armed <= wh || rh || (armed && !sys_reset);
    end
  end
  sequence load_s;
    wh ##2 1'b1;
  endsequence
  // The pulse is measured by counting its cycles, so any pulse length parameter is served.
  sequence pulse_s;
    sys_reset ##1 !sys_reset;
  endsequence
  ctl_load_a: assert property (load_s |-> watchdog_control_out == $past(io_wdata, 2)) else $error("load");
  ctl_hold_a: assert property (!$past(wh, 2) |-> $stable(watchdog_control_out)) else $error("hold");
  rd_data_a: assert property (rh && !io_wr |=> io_rdata == watchdog_control_out) else $error("rdata");
  rd_idle_a: assert property (!rh |=> io_rdata == 8'h00) else $error("idle");
  init_zero_a: assert property ($rose(rstn) |-> watchdog_control_out == 8'h00 && !sys_reset) else $error("init");
  en_gate_a: assert property ($rose(sys_reset) |-> $past(watchdog_control_out[3])) else $error("gate");
  pulse_len_a: assert property (pulse_s |-> hi == RESET_PULSE_CYCLES) else $error("pulse");
  timeout_len_a: assert property ($rose(sys_reset) && armed |-> cnt >= lim && cnt <= lim + 4) else $error("time");
endmodule

// ===== iowd_host.sv
`timescale 1ns/1ps
module iowd_host (
  input wire logic mclk,
  output logic [7:0] io_addr,
  output logic io_rd,
  output logic io_wr,
  output logic [7:0] io_wdata
);
  initial {io_addr, io_rd, io_wr, io_wdata} = '0;
  // Released data is inverted so a stale byte never looks valid.
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1 {io_addr, io_rd, io_wr, io_wdata} = {a, rd, !rd, d};
    @(posedge mclk);
    #1 {io_rd, io_wr, io_wdata} = {2'b00, ~d};
  endtask
endmodule

// ===== iowd_tb_top.sv
`timescale 1ns/1ps
module iowd_tb_top;
  logic mclk = 0, rstn = 0, io_rd, io_wr, sys_reset, pend = 0;
  logic [7:0] io_addr, io_wdata, io_rdata, watchdog_control_out, b, ctl = 0;
  logic [7:0] expq[$];
  int err_total = 0, tests_run = 0, seed = 81, n;
  always #12.5 mclk = ~mclk;
  iowd_host host (.mclk(mclk), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata));
  iowd_top #(.TICK_CYCLES(10), .RESET_PULSE_CYCLES(4)) dut (.mclk(mclk), .rstn(rstn), .io_addr(io_addr),
    .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata), .sys_reset(sys_reset),
    .watchdog_control_out(watchdog_control_out));
  task automatic chk(input string s, input logic [31:0] e, g);
    tests_run++;
    if (e !== g) begin
      err_total++;
      $display("mismatch %s exp %0h got %0h", s, e, g);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rd;
    expq.push_back(ctl);
    host.xfer(1'b1, 8'hF2, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, d);
    if (a == 8'hF2) ctl = d;
    host.xfer(1'b0, a, d);
  endtask
  always @(negedge mclk) begin
    if (pend) chk("io_rdata", expq.pop_front(), io_rdata);
    pend = io_rd && io_addr == 8'hF2;
  end
  initial begin
    repeat (10) @(posedge mclk);
    #1 rstn = 1;
    rd();
    for (int k = 0; k < 8; k++) begin
      b = $random(seed);
      b[3:0] = {1'b1, k[2:0]};
      rd();
      wr(8'hF2, b);
      n = 0;
      while (sys_reset !== 1'b1) begin
        @(posedge mclk);
        #1 n++;
        if (n > 1400) begin
          err_total++;
          finish_test;
        end
      end
      chk("timeout", 1, n > (10 << (k ? k - 1 : 7)) && n <= (10 << (k ? k - 1 : 7)) + 5);
      chk("control", b, watchdog_control_out);
      repeat (3) @(posedge mclk);
      #1 chk("pulse", 1, sys_reset);
      @(posedge mclk);
      #1 chk("pulse", 0, sys_reset);
    end
    wr(8'hF3, 8'hFF);
    rd();
    wr(8'hF2, 8'h09);
    repeat (8) begin
      host.xfer(1'b1, 8'h20, 8'h00);
      rd();
      chk("service", 0, sys_reset);
    end
    wr(8'hF2, 8'h01);
    repeat (30) begin
      repeat (10) @(posedge mclk);
      #1 chk("disabled", 0, sys_reset);
    end
    finish_test;
  end
endmodule
bind iowd_top iowd_chk #(.TICK_CYCLES(TICK_CYCLES), .RESET_PULSE_CYCLES(RESET_PULSE_CYCLES)) chk_i (
  .mclk(mclk), .rstn(rstn), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
  .io_rdata(io_rdata), .sys_reset(sys_reset), .watchdog_control_out(watchdog_control_out));
